// ===== src/fcg_gate_status.sv
// Fan control gate register and first fault status register
// How it works
// R1: Start bit one selects programmed fan limits from 5Ch..6Eh.
// R2: Start bit zero selects built-in defaults, ignoring programmed registers.
// R3: Toggling start never alters limit or parameter register contents.
// R4: Start bit stays writable whatever the lock bit says.
// R5: Software should program limits before setting start; not enforced.
// R6: Lock set makes limit and parameter registers read-only until power-off.
// R7: Once set, the lock bit ignores all writes.
// R8: Ready flag set by hardware after reset done and converters working.
// R9: Override one forces every PWM output to full duty.
// R10: Override also forces disabled PWM channels to full duty.
// R11: Status flag sets when value lies outside its limit window.
// R12: Zone 1 and zone 3 flags also set on remote diode faults.
// R13: Several flags may be pending; one read returns them all.
// R14: Set flag holds until software reads, even if fault cleared.
// R15: After a read, flags clear unless their fault persists.
// R16: Status register is read-only; writes change nothing.
// R17: Bits: 2.5V, core, 3.3V, 5V, zones 1..3, status-2 summary.
// R18: Out of window means at or below low, or above high.
// R19: Control bits: start, lock, ready, override; bits 4..7 read zero.
// R20: Fault arriving during the read cycle survives the read clear.
`timescale 1ns/1ps
module fcg_gate_status #(
    parameter int NUM_PWM = 3,
    parameter int NUM_V   = 4,
    parameter int NUM_T   = 3
) (
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // Register access from the serial host engine (same clock)
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_wdata,
    output      logic [7:0]          reg_rdata,
    // Lock gate for writes to the fan parameter registers
    output      logic                param_wr_ok,
    // Device health
    input  wire logic                powerup_done,
    input  wire logic                adc_ok,
    // Measurements and limits, packed by channel
    input  wire logic [NUM_V*8-1:0]  volt_value,
    input  wire logic [NUM_V*8-1:0]  volt_low,
    input  wire logic [NUM_V*8-1:0]  volt_high,
    input  wire logic [NUM_T*8-1:0]  temp_value,
    input  wire logic [NUM_T*8-1:0]  temp_low,
    input  wire logic [NUM_T*8-1:0]  temp_high,
    input  wire logic                remote_diode_a_fault,
    input  wire logic                remote_diode_b_fault,
    input  wire logic                status_two_any,
    // Fan control path
    input  wire logic [NUM_PWM*8-1:0] pwm_duty_req,
    output      logic                use_programmed,
    output      logic [NUM_PWM*8-1:0] pwm_duty_out
);
    // ****************************************************************
    // Decoding
    // ****************************************************************
    logic       start_bit;
    logic       lock_bit;
    logic       ready_bit;
    logic       force_full_duty;
    logic [7:0] fault_status_one;
    logic [7:0] control_view;
    logic [7:0] fault_now;
    logic [NUM_V-1:0] volt_out;
    logic [NUM_T-1:0] temp_out;

    wire sel_ctl   = (reg_addr == fcg_pkg::OFS_CONTROL_GATE);
    wire sel_stat  = (reg_addr == fcg_pkg::OFS_FAULT_STATUS);
    wire in_params = (reg_addr >= fcg_pkg::OFS_FAN_PARAM_LO) &&
                     (reg_addr <= fcg_pkg::OFS_FAN_PARAM_HI);
    wire ctl_wr    = clk_en && reg_wr && sel_ctl;
    wire stat_rd   = clk_en && reg_rd && sel_stat;

    // Reserved bits read zero [R19]
    assign control_view = {4'h0, force_full_duty, ready_bit,
                           lock_bit, start_bit}; // [R19]

    // ****************************************************************
    // Window comparators
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_V; gi++) begin : g_volt
            fcg_window_cmp #(.WIDTH(8)) u_cmp (
                .value      (volt_value[gi*8 +: 8]),
                .low_limit  (volt_low[gi*8 +: 8]),
                .high_limit (volt_high[gi*8 +: 8]),
                .outside    (volt_out[gi])
            );
        end
        for (gi = 0; gi < NUM_T; gi++) begin : g_temp
            fcg_window_cmp #(.WIDTH(8)) u_cmp (
                .value      (temp_value[gi*8 +: 8]),
                .low_limit  (temp_low[gi*8 +: 8]),
                .high_limit (temp_high[gi*8 +: 8]),
                .outside    (temp_out[gi])
            );
        end
    endgenerate

    // Live fault vector in status bit order [R11] [R17]
    assign fault_now[fcg_pkg::BIT_V2P5]   = volt_out[0]; // [R17]
    assign fault_now[fcg_pkg::BIT_VCORE]  = volt_out[1];
    assign fault_now[fcg_pkg::BIT_V3P3]   = volt_out[2];
    assign fault_now[fcg_pkg::BIT_V5]     = volt_out[3];
    // Diode faults join the remote zones [R12]
    assign fault_now[fcg_pkg::BIT_ZONE_A] =
        temp_out[0] | remote_diode_a_fault; // [R12]
    assign fault_now[fcg_pkg::BIT_ZONE_I] = temp_out[1];
    assign fault_now[fcg_pkg::BIT_ZONE_B] =
        temp_out[2] | remote_diode_b_fault; // [R12]
    assign fault_now[fcg_pkg::BIT_STAT2]  = status_two_any; // [R17]

    // Sticky hold; a read keeps only live faults, so same-cycle
    // events survive the clear [R14] [R15] [R20]
    wire [7:0] next_fault_status = stat_rd ? fault_now
                                 : (fault_status_one | fault_now);

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Start writable regardless of lock [R4]; lock is one-way [R7]
    wire next_start = ctl_wr ? reg_wdata[fcg_pkg::BIT_START] : start_bit;
    wire next_lock  = lock_bit | (ctl_wr & reg_wdata[fcg_pkg::BIT_LOCK]);
    wire next_force = ctl_wr ? reg_wdata[fcg_pkg::BIT_FORCE]
                             : force_full_duty;
    // Ready only from hardware; writes to it are ignored [R8]
    wire next_ready = powerup_done & adc_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_bit       <= fcg_pkg::RST_CONTROL_GATE[fcg_pkg::BIT_START];
            lock_bit        <= fcg_pkg::RST_CONTROL_GATE[fcg_pkg::BIT_LOCK];
            force_full_duty <= fcg_pkg::RST_CONTROL_GATE[fcg_pkg::BIT_FORCE];
            ready_bit       <= fcg_pkg::RST_CONTROL_GATE[fcg_pkg::BIT_READY];
        end else if (clk_en) begin
            start_bit       <= next_start;        // [R4]
            lock_bit        <= next_lock;         // [R7]
            force_full_duty <= next_force;
            ready_bit       <= next_ready;        // [R8]
        end
    end

    // Status flags; writes never reach them [R16] [R13]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_status_one <= fcg_pkg::RST_FAULT_STATUS;
        end else if (clk_en) begin
            fault_status_one <= next_fault_status; // [R14] [R15] [R16]
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Read data registered; whole status byte returned at once [R13]
    wire [7:0] rdata_sel = sel_ctl  ? control_view
                         : sel_stat ? fault_status_one : 8'h00;

    // Override beats any channel setting, disabled included [R9] [R10]
    logic [NUM_PWM*8-1:0] next_duty;
    always_comb begin
        for (int i = 0; i < NUM_PWM; i++) begin
            next_duty[i*8 +: 8] = next_force ? fcg_pkg::DUTY_FULL
                                             : pwm_duty_req[i*8 +: 8];
        end
    end

    // Programmed values only when start set [R1] [R2]; parameter
    // writes blocked once locked [R6]. Start never touches them [R3].
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata      <= 8'h00;
            param_wr_ok    <= 1'b1;
            use_programmed <= 1'b0;
            pwm_duty_out   <= '0;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata <= rdata_sel;   // [R13]
            end
            param_wr_ok    <= ~next_lock; // [R6]
            use_programmed <= next_start; // [R1] [R2] [R3]
            pwm_duty_out   <= next_duty;  // [R9] [R10]
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Lock never falls once set
    AST_LOCK_STICKS: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        lock_bit |=> lock_bit)
        else $error("lock bit cleared after being set");

    // Gate closes as soon as the lock is held
    AST_PARAM_BLOCK: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && lock_bit) |=> !param_wr_ok)
        else $error("parameter writes allowed while locked");

    // A write into the parameter range under lock finds the gate shut
    AST_PARAM_WR_LOCKED: assert property ( // [R6]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_wr && in_params && lock_bit) |-> !param_wr_ok)
        else $error("parameter range write not gated by lock");

    // Start still follows software under lock
    AST_START_FREE: assert property ( // [R4]
        @(posedge clk) disable iff (!rst_n)
        (ctl_wr && lock_bit) |=>
            start_bit == $past(reg_wdata[fcg_pkg::BIT_START]))
        else $error("start bit not writable under lock");

    // Start set selects programmed limits on the next edge
    AST_START_SEL: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && next_start) |=> use_programmed)
        else $error("programmed values not used while start set");

    // Start clear falls back to the built-in defaults
    AST_SEL_MODE: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !next_start) |=> !use_programmed)
        else $error("programmed values used while start clear");

    // Override drives every channel to full duty
    AST_FULL_DUTY: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && next_force) |=>
            pwm_duty_out == {NUM_PWM{fcg_pkg::DUTY_FULL}})
        else $error("override did not force full duty");

    // Ready follows hardware health only, never the write data
    AST_READY_HW: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_n)
        clk_en |=>
            ready_bit == ($past(powerup_done) && $past(adc_ok)))
        else $error("ready flag not driven by hardware health");

    // No flag drops without a read
    AST_STICKY: assert property ( // [R14]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !stat_rd) |=>
            ((fault_status_one & $past(fault_status_one))
             == $past(fault_status_one)))
        else $error("status flag lost without a read");

    // A read keeps exactly the faults still present
    AST_READ_CLEAR: assert property ( // [R15]
        @(posedge clk) disable iff (!rst_n)
        stat_rd |=> fault_status_one == $past(fault_now))
        else $error("read did not reload live faults");

    // Every live fault shows up one edge later
    AST_SETS: assert property ( // [R11]
        @(posedge clk) disable iff (!rst_n)
        clk_en |=> ((fault_status_one & $past(fault_now))
                    == $past(fault_now)))
        else $error("live fault not flagged");

    // Low-limit boundary counts as outside the window
    AST_LOW_EDGE: assert property ( // [R18]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && (volt_value[7:0] <= volt_low[7:0])) |=>
            fault_status_one[fcg_pkg::BIT_V2P5])
        else $error("value at low limit not flagged");

    // First remote diode fault raises its zone flag
    AST_DIODE_A: assert property ( // [R12]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && remote_diode_a_fault) |=>
            fault_status_one[fcg_pkg::BIT_ZONE_A])
        else $error("first diode fault not flagged");

    // Second remote diode fault raises its zone flag
    AST_DIODE_B: assert property ( // [R12]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && remote_diode_b_fault) |=>
            fault_status_one[fcg_pkg::BIT_ZONE_B])
        else $error("second diode fault not flagged");

    // Top bit summarises the second status register
    AST_SUMMARY: assert property ( // [R17]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && status_two_any) |=>
            fault_status_one[fcg_pkg::BIT_STAT2])
        else $error("status two summary not flagged");

    // Writes to the status byte change nothing
    AST_NO_STATUS_WRITE: assert property ( // [R16]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_wr && sel_stat && !reg_rd) |=>
            fault_status_one ==
                ($past(fault_status_one) | $past(fault_now)))
        else $error("write altered the status flags");

    // One read hands over the whole pending byte
    AST_READ_WHOLE: assert property ( // [R13]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_rd && sel_stat) |=>
            reg_rdata == $past(fault_status_one))
        else $error("status read did not return all flags");

    // Control read: field order fixed, reserved bits zero
    AST_RSVD_ZERO: assert property ( // [R19]
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_rd && sel_ctl) |=>
            reg_rdata == {4'h0, $past(force_full_duty), $past(ready_bit),
                          $past(lock_bit), $past(start_bit)})
        else $error("control read fields wrong");
endmodule

// ===== src/fcg_pkg.sv
// Package: register map, field positions and reset values of the gate block
package fcg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CONTROL_GATE = 8'h40;
    localparam logic [7:0] OFS_FAULT_STATUS = 8'h41;
    // Range of the fan limit and parameter registers
    localparam logic [7:0] OFS_FAN_PARAM_LO = 8'h5c;
    localparam logic [7:0] OFS_FAN_PARAM_HI = 8'h6e;
    // Control register fields
    localparam int BIT_START  = 0;
    localparam int BIT_LOCK   = 1;
    localparam int BIT_READY  = 2;
    localparam int BIT_FORCE  = 3;
    // Fault status fields
    localparam int BIT_V2P5   = 0;
    localparam int BIT_VCORE  = 1;
    localparam int BIT_V3P3   = 2;
    localparam int BIT_V5     = 3;
    localparam int BIT_ZONE_A = 4;
    localparam int BIT_ZONE_I = 5;
    localparam int BIT_ZONE_B = 6;
    localparam int BIT_STAT2  = 7;
    // Reset values
    localparam logic [7:0] RST_CONTROL_GATE = 8'h00;
    localparam logic [7:0] RST_FAULT_STATUS = 8'h00;
    // Full duty code
    localparam logic [7:0] DUTY_FULL = 8'hff;
endpackage

// ===== src/fcg_window_cmp.sv
// Out-of-window comparator for one measured value
`timescale 1ns/1ps
module fcg_window_cmp #(
    parameter int WIDTH = 8
) (
    // Measurement and limits
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [WIDTH-1:0] low_limit,
    input  wire logic [WIDTH-1:0] high_limit,
    // Result
    output      logic             outside
);
    // At or below low, or strictly above high [R18]
    assign outside = (value <= low_limit) || (value > high_limit); // [R18]
endmodule

// ===== verification/fcg_host_model.sv
// Host engine model issuing single-byte register accesses
`timescale 1ns/1ps
module fcg_host_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output      logic [7:0] reg_addr,
    output      logic       reg_wr,
    output      logic       reg_rd,
    output      logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // Idle values at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One access: strobe held over one rising edge, result sampled after it
    task automatic access(input logic [7:0] a, input logic w,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = ~w;
        @(posedge clk);
        @(negedge clk);
        q         = reg_rdata;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // Inverted leftovers, so a stale bus never looks valid
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// ===== verification/fcg_gate_status_tb.sv
// Self-checking bench for the fan control gate and fault status block
`timescale 1ns/1ps
module fcg_gate_status_tb;
    logic        clk, rst_n, clk_en, reg_wr, reg_rd, param_wr_ok;
    logic        powerup_done, adc_ok, use_programmed, status_two_any;
    logic        remote_diode_a_fault, remote_diode_b_fault;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
    logic [31:0] volt_value, volt_low, volt_high;
    logic [23:0] temp_value, temp_low, temp_high, pwm_duty_req, pwm_duty_out;
    int          n_errors = 0;
    int          compares = 0;

    fcg_gate_status dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .param_wr_ok(param_wr_ok), .powerup_done(powerup_done),
        .adc_ok(adc_ok), .volt_value(volt_value), .volt_low(volt_low),
        .volt_high(volt_high), .temp_value(temp_value),
        .temp_low(temp_low), .temp_high(temp_high),
        .remote_diode_a_fault(remote_diode_a_fault),
        .remote_diode_b_fault(remote_diode_b_fault),
        .status_two_any(status_two_any), .pwm_duty_req(pwm_duty_req),
        .use_programmed(use_programmed), .pwm_duty_out(pwm_duty_out));
    fcg_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Shared helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-bit outputs, widened on purpose to the checker's width
    task automatic chk_bit(input logic seen, input logic exp);
        chk({23'h000000, seen}, {23'h000000, exp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.access(a, 1'b0, 8'h00, q);
        chk({16'h0000, q}, {16'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d, q);
    endtask
    // Quiet measurements: every channel well inside its window
    task automatic calm();
        volt_value = 32'h80808080;
        temp_value = 24'h808080;
        remote_diode_a_fault = 1'b0;
        remote_diode_b_fault = 1'b0;
        status_two_any = 1'b0;
    endtask

    task automatic t_reset();
        chk_bit(param_wr_ok, 1'b1);
        chk_bit(use_programmed, 1'b0);
        rd(8'h40, 8'h00);
        rd(8'h41, 8'h00);
        powerup_done = 1'b1;
        rd(8'h40, 8'h00);
        adc_ok = 1'b1;
        rd(8'h40, 8'h04);
        rd(8'h3f, 8'h00);
        $display("test reset done");
    endtask

    // No limit registers here, so start may be set at once
    task automatic t_start_force();
        wr(8'h40, 8'hf9);
        rd(8'h40, 8'h0d);
        chk_bit(use_programmed, 1'b1);
        chk(pwm_duty_out, 24'hffffff);
        wr(8'h40, 8'h00);
        rd(8'h40, 8'h04);
        chk_bit(use_programmed, 1'b0);
        chk(pwm_duty_out, pwm_duty_req);
        $display("test start and override done");
    endtask

    task automatic t_lock();
        clk_en = 1'b0;
        wr(8'h40, 8'h02);
        clk_en = 1'b1;
        chk_bit(param_wr_ok, 1'b1);
        wr(8'h40, 8'h02);
        rd(8'h40, 8'h06);
        chk_bit(param_wr_ok, 1'b0);
        // Write into the parameter range while locked
        wr(8'h5c, 8'h55);
        chk_bit(param_wr_ok, 1'b0);
        wr(8'h40, 8'h09);
        rd(8'h40, 8'h0f);
        chk_bit(use_programmed, 1'b1);
        chk(pwm_duty_out, 24'hffffff);
        $display("test lock done");
    endtask

    task automatic t_status();
        // Boundaries: at low, at high, one above high
        volt_value = 32'h80f1f010;
        temp_value = 24'h80ff80;
        remote_diode_a_fault = 1'b1;
        status_two_any = 1'b1;
        @(negedge clk);
        calm();
        rd(8'h41, 8'hb5);
        rd(8'h41, 8'h00);
        remote_diode_b_fault = 1'b1;
        @(negedge clk);
        wr(8'h41, 8'h00);
        rd(8'h41, 8'h40);
        rd(8'h41, 8'h40);
        remote_diode_b_fault = 1'b0;
        rd(8'h41, 8'h40);
        rd(8'h41, 8'h00);
        // Faults that appear only in the read cycle itself
        fork
            host.access(8'h41, 1'b0, 8'h00, q);
            begin
                @(negedge clk);
                volt_value = 32'h05800f80;
                temp_value = 24'hf58005;
            end
        join
        calm();
        chk({16'h0000, q}, 24'h000000);
        rd(8'h41, 8'h5a);
        rd(8'h41, 8'h00);
        $display("test status done");
    endtask

    // Verdict and end of run
    task automatic results();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        powerup_done = 1'b0;
        adc_ok = 1'b0;
        volt_low = 32'h10101010;
        volt_high = 32'hf0f0f0f0;
        temp_low = 24'h101010;
        temp_high = 24'hf0f0f0;
        pwm_duty_req = 24'h004000;
        calm();
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_start_force();
        t_lock();
        t_status();
        results();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100us;
        n_errors++;
        results();
    end
endmodule
